// File: include/fqg_pkg.sv
// Purpose: shared constants of the guarded queue and its controller
// Assumes: one clock, byte addressed register bus with 32-bit words
// Notes:   queue defaults are plain sizes; override at instantiation
package fqg_pkg;
  // ----------------------------------------------------------------
  // queue defaults
  // ----------------------------------------------------------------
  localparam int FQG_DATA_W = 8;
  localparam int FQG_DEPTH = 8;
  localparam int FQG_AE_VALUE = 1;
  localparam int FQG_WR_LAT = 2;
  localparam bit FQG_OVF_GUARD = 1'b1;
  localparam bit FQG_UNF_GUARD = 1'b1;
  localparam bit FQG_WRCYCLE_FULL = 1'b0;
  // ----------------------------------------------------------------
  // controller register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int FQG_ADDR_W = 5;
  localparam logic [4:0] FQG_CTRL_OFS = 5'h00;
  localparam logic [4:0] FQG_STATUS_OFS = 5'h04;
  localparam logic [4:0] FQG_WDATA_OFS = 5'h08;
  localparam logic [4:0] FQG_RDATA_OFS = 5'h0c;
  localparam logic [4:0] FQG_IRQ_STAT_OFS = 5'h10;
  localparam logic [4:0] FQG_IRQ_MASK_OFS = 5'h14;
  // ctrl bit: writing one asks for one word to be popped
  localparam int FQG_CTRL_POP_BIT = 0;
  // status bits; used-word count sits from FQG_ST_USEDW_LSB upward
  localparam int FQG_ST_PEND_WR_BIT = 0;
  localparam int FQG_ST_PEND_RD_BIT = 1;
  localparam int FQG_ST_FULL_BIT = 2;
  localparam int FQG_ST_EMPTY_BIT = 3;
  localparam int FQG_ST_AE_BIT = 4;
  localparam int FQG_ST_USEDW_LSB = 8;
  // interrupt events
  localparam int FQG_IRQ_W = 3;
  localparam int FQG_IRQ_PUSHED_BIT = 0;
  localparam int FQG_IRQ_POPPED_BIT = 1;
  localparam int FQG_IRQ_DROPPED_BIT = 2;
  localparam logic [FQG_IRQ_W-1:0] FQG_IRQ_MASK_RST = 3'h0;
endpackage

// File: include/fqg_link_if.sv
// Purpose: request and flag wires between queue and its producer/consumer
// Assumes: both ends on the same clock
// Notes:   no clocking block; the bench joins the two ends through this
`timescale 1ns/1ps
interface fqg_link_if #(
  parameter int DATA_W = 8,
  parameter int CNT_W = 4
);
  logic wrreq;
  logic [DATA_W-1:0] data;
  logic rdreq;
  logic [DATA_W-1:0] q;
  logic full;
  logic empty;
  logic almost_empty;
  logic [CNT_W-1:0] usedw;

  modport queue (
    input wrreq, data, rdreq,
    output q, full, empty, almost_empty, usedw
  );
  modport user (
    output wrreq, data, rdreq,
    input q, full, empty, almost_empty, usedw
  );
endinterface

// File: rtl/fqg_queue.sv
// Purpose: single clock first-in first-out queue with optional guards
// Assumes: normal (not show-ahead) output, q updates one cycle after a read
// Notes:   empty clears WR_LAT cycles after a write; count moves after one
//
// Summary of operation
// - overflow guard drops writes while full
// - underflow guard drops reads while empty
// - unguarded: producer drops write when full asserts
// - unguarded: consumer drops read when empty asserts
// - near-empty high exactly when count below threshold
// - near-empty uses count only, not output readiness
// - threshold one: near-empty only at count zero
// - accepted write plus read leaves count unchanged
// - empty clears only after write latency
// - full-cycle option: read plus write while full
`timescale 1ns/1ps
module fqg_queue #(
  parameter int DATA_W = fqg_pkg::FQG_DATA_W,
  parameter int DEPTH = fqg_pkg::FQG_DEPTH,
  parameter int AE_VALUE = fqg_pkg::FQG_AE_VALUE,
  parameter int WR_LAT = fqg_pkg::FQG_WR_LAT,
  parameter bit OVF_GUARD = fqg_pkg::FQG_OVF_GUARD,
  parameter bit UNF_GUARD = fqg_pkg::FQG_UNF_GUARD,
  parameter bit WRCYCLE_FULL = fqg_pkg::FQG_WRCYCLE_FULL
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  fqg_link_if.queue link
);
  import fqg_pkg::*;

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH) + 1;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] AE_THR = CNT_W'(AE_VALUE);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("depth must be a power of two of at least two");
  end
  if (WR_LAT < 1 || WR_LAT > 2) begin : g_bad_lat
    $error("write latency to empty must be one or two cycles");
  end
  if (AE_VALUE < 0 || AE_VALUE > DEPTH) begin : g_bad_ae
    $error("near-empty threshold out of range");
  end
  if (WRCYCLE_FULL && !OVF_GUARD) begin : g_bad_cyc
    $error("full-cycle option needs the overflow guard");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [CNT_W-1:0] cnt;
    logic pend;
    logic full;
    logic empty;
    logic ae;
    logic [DATA_W-1:0] q;
  } fqg_queue_state_t;

  fqg_queue_state_t s_reg;
  fqg_queue_state_t s_next;
  logic wr_ok;
  logic rd_ok;

  // ------------------------------------------------------------------
  // request qualification and next state
  // ------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // guard against the visible empty flag, so a word still inside its
    // write latency cannot be popped before the flag admits it
    rd_ok = link.rdreq && !(UNF_GUARD && s_reg.empty);
    // full-cycle option: a read frees the slot in the same edge
    wr_ok = link.wrreq && !(OVF_GUARD && s_reg.full
                            && !(WRCYCLE_FULL && rd_ok));
    if (wr_ok) begin
      s_next.mem[s_reg.wptr] = link.data;
      s_next.wptr = s_reg.wptr + PTR_ONE;
    end
    if (rd_ok) begin
      s_next.q = s_reg.mem[s_reg.rptr];
      s_next.rptr = s_reg.rptr + PTR_ONE;
    end
    if (wr_ok && !rd_ok) begin
      s_next.cnt = s_reg.cnt + CNT_ONE;
    end else if (rd_ok && !wr_ok) begin
      s_next.cnt = s_reg.cnt - CNT_ONE;
    end
    // both accepted: count held as is
    s_next.pend = (WR_LAT == 2) ? wr_ok : 1'b0;
    s_next.full = (s_next.cnt == CNT_FULL);
    // a pending word is counted but not yet readable
    s_next.empty = ((s_next.cnt - CNT_W'(s_next.pend)) == '0);
    // count alone; output readiness is not considered
    s_next.ae = (s_next.cnt < AE_THR);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
      s_reg.empty <= 1'b1;
      s_reg.ae <= (AE_VALUE > 0);
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign link.q = s_reg.q;
  assign link.full = s_reg.full;
  assign link.empty = s_reg.empty;
  assign link.almost_empty = s_reg.ae;
  assign link.usedw = s_reg.cnt;

endmodule // fqg_queue

// File: rtl/fqg_ctrl.sv
// Purpose: producer/consumer end; software pushes and pops over Avalon-MM
// Assumes: queue in normal output mode, q valid one cycle after rdreq
// Notes:   every access answers one cycle after it is presented
`timescale 1ns/1ps
module fqg_ctrl #(
  parameter int DATA_W = fqg_pkg::FQG_DATA_W,
  parameter int CNT_W = $clog2(fqg_pkg::FQG_DEPTH) + 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [fqg_pkg::FQG_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  fqg_link_if.user link
);
  import fqg_pkg::*;

  if (DATA_W > 32 || CNT_W + FQG_ST_USEDW_LSB > 32) begin : g_bad_w
    $error("queue word or count too wide for a 32-bit register");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic pend_wr;
    logic pend_rd;
    logic cap;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [31:0] rd;
    logic [FQG_IRQ_W-1:0] stat;
    logic [FQG_IRQ_W-1:0] mask;
  } fqg_ctrl_state_t;

  fqg_ctrl_state_t s_reg;
  fqg_ctrl_state_t s_next;
  logic req;
  logic take;
  logic wr_go;
  logic rd_go;
  logic [FQG_IRQ_W-1:0] ev;
  logic [31:0] status;

  // ------------------------------------------------------------------
  // queue requests
  // ------------------------------------------------------------------
  // requests fall in the very cycle the flag rises, whether or not the
  // queue guards itself
  assign wr_go = s_reg.pend_wr && !link.full;
  assign rd_go = s_reg.pend_rd && !link.empty;
  assign link.wrreq = wr_go;
  assign link.rdreq = rd_go;
  assign link.data = s_reg.wdata;

  // ------------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------------
  assign req = avs_read_i || avs_write_i;
  assign take = req && s_reg.ack;
  assign avs_waitrequest_o = req && !s_reg.ack;
  assign avs_readdata_o = s_reg.rd;
  assign irq_o = |(s_reg.stat & s_reg.mask);

  always_comb begin
    status = '0;
    status[FQG_ST_PEND_WR_BIT] = s_reg.pend_wr;
    status[FQG_ST_PEND_RD_BIT] = s_reg.pend_rd;
    status[FQG_ST_FULL_BIT] = link.full;
    status[FQG_ST_EMPTY_BIT] = link.empty;
    status[FQG_ST_AE_BIT] = link.almost_empty;
    status[FQG_ST_USEDW_LSB +: CNT_W] = link.usedw;
  end

  always_comb begin
    s_next = s_reg;
    ev = '0;
    s_next.ack = req && !s_reg.ack;
    if (wr_go) begin
      s_next.pend_wr = 1'b0;
      ev[FQG_IRQ_PUSHED_BIT] = 1'b1;
    end
    if (rd_go) begin
      s_next.pend_rd = 1'b0;
    end
    s_next.cap = rd_go;
    if (s_reg.cap) begin
      s_next.rdata = link.q;
      ev[FQG_IRQ_POPPED_BIT] = 1'b1;
    end
    if (req && !s_reg.ack) begin
      unique case (avs_address_i)
        FQG_STATUS_OFS: s_next.rd = status;
        FQG_RDATA_OFS: s_next.rd = 32'(s_reg.rdata);
        FQG_IRQ_STAT_OFS: s_next.rd = 32'(s_reg.stat);
        FQG_IRQ_MASK_OFS: s_next.rd = 32'(s_reg.mask);
        default: s_next.rd = '0;
      endcase
    end
    if (take && avs_write_i) begin
      unique case (avs_address_i)
        FQG_WDATA_OFS: begin
          // one word in flight; a second push while it waits is lost
          if (s_reg.pend_wr) begin
            ev[FQG_IRQ_DROPPED_BIT] = 1'b1;
          end else begin
            s_next.pend_wr = 1'b1;
            s_next.wdata = avs_writedata_i[DATA_W-1:0];
          end
        end
        FQG_CTRL_OFS: begin
          if (avs_writedata_i[FQG_CTRL_POP_BIT]) begin
            if (s_reg.pend_rd || s_reg.cap) begin
              ev[FQG_IRQ_DROPPED_BIT] = 1'b1;
            end else begin
              s_next.pend_rd = 1'b1;
            end
          end
        end
        FQG_IRQ_STAT_OFS: s_next.stat = s_reg.stat & ~avs_writedata_i[FQG_IRQ_W-1:0];
        FQG_IRQ_MASK_OFS: s_next.mask = avs_writedata_i[FQG_IRQ_W-1:0];
        default: ;
      endcase
    end
    // new events win over a clear in the same cycle
    s_next.stat = s_next.stat | ev;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
      s_reg.mask <= FQG_IRQ_MASK_RST;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule // fqg_ctrl

// File: dv/fqg_link_monitor.sv
// Purpose: concurrent checks on the link between queue and controller
// Assumes: link a unguarded behind the controller, link b guarded, write latency 2
// Notes:   plain inputs; the bench instantiates it beside the link
`timescale 1ns/1ps
module fqg_link_monitor #(
  parameter int DATA_W = 8,
  parameter int CNT_W = 4,
  parameter int DEPTH = 8,
  parameter int AE_VALUE = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wrreq,
  input wire logic [DATA_W-1:0] data,
  input wire logic rdreq,
  input wire logic [DATA_W-1:0] q,
  input wire logic full,
  input wire logic empty,
  input wire logic almost_empty,
  input wire logic [CNT_W-1:0] usedw,
  input wire logic b_wrreq,
  input wire logic b_rdreq,
  input wire logic b_full,
  input wire logic b_empty,
  input wire logic [CNT_W-1:0] b_usedw
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // guard checks watch the guarded queue, which the bench pushes past its limits
  property p_ovf_drop; b_full && b_wrreq && !b_rdreq |=> $stable(b_usedw) && b_full; endproperty
  property p_unf_drop; b_empty && b_rdreq && !b_wrreq |=> $stable(b_usedw); endproperty
  property p_wr_stop; full |-> !wrreq; endproperty
  property p_rd_stop; empty |-> !rdreq; endproperty
  property p_near_empty; almost_empty == (usedw < CNT_W'(AE_VALUE)); endproperty
  property p_both; b_wrreq && b_rdreq && !b_full && !b_empty |=> $stable(b_usedw); endproperty
  // empty must hold through the write latency before it clears
  property p_empty_lat; wrreq && !rdreq && empty && usedw == '0 |=> empty ##1 !empty; endproperty
  property p_push; wrreq && !full && !rdreq |=> usedw == $past(usedw) + 1'b1; endproperty
  property p_pop; rdreq && !empty && !wrreq |=> usedw == $past(usedw) - 1'b1; endproperty
  a_ovf_drop: assert property (p_ovf_drop) else $error("write taken while full");
  a_unf_drop: assert property (p_unf_drop) else $error("read taken while empty");
  a_wr_stop: assert property (p_wr_stop) else $error("write request while full");
  a_rd_stop: assert property (p_rd_stop) else $error("read request while empty");
  a_near_empty: assert property (p_near_empty) else $error("near-empty wrong");
  a_both: assert property (p_both) else $error("count moved on read plus write");
  a_empty_lat: assert property (p_empty_lat) else $error("empty cleared early");
  a_push: assert property (p_push) else $error("count not raised");
  a_pop: assert property (p_pop) else $error("count not lowered");
  c_full: cover property (full);
  c_gap: cover property (empty && !almost_empty);
  c_lat: cover property (empty && usedw != '0);
endmodule // fqg_link_monitor

// File: dv/test_fifo_request_guard_flags.sv
// Purpose: self-checking bench for queue plus controller and a guard provoker
// Assumes: package defaults: depth 8, threshold 1, write latency 2, guards on
// Notes:   second queue is driven directly so its guards can be provoked
`timescale 1ns/1ps
module test_fifo_request_guard_flags;
  import fqg_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic irq_o;
  logic [31:0] rd;
  logic [7:0] model[$];
  logic [7:0] w;
  logic [7:0] last_w;
  int seed = 32'h811d42c4;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  fqg_link_if #(.DATA_W(8), .CNT_W(4)) link_a ();
  fqg_link_if #(.DATA_W(8), .CNT_W(4)) link_b ();
  fqg_link_if #(.DATA_W(8), .CNT_W(4)) link_c ();
  // controller queue runs unguarded: only the request gating keeps it sane
  fqg_queue #(.OVF_GUARD(1'b0), .UNF_GUARD(1'b0)) i_fqg_queue (
    .clk_i(clk_i), .rstn_i(rstn_i), .link(link_a));
  fqg_queue i_fqg_queue_b (.clk_i(clk_i), .rstn_i(rstn_i), .link(link_b));
  fqg_queue #(.WRCYCLE_FULL(1'b1)) i_fqg_queue_c (
    .clk_i(clk_i), .rstn_i(rstn_i), .link(link_c));
  fqg_ctrl i_fqg_ctrl (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o), .link(link_a));
  fqg_link_monitor #(.DEPTH(FQG_DEPTH), .AE_VALUE(FQG_AE_VALUE)) i_fqg_link_monitor (
    .clk_i(clk_i), .rstn_i(rstn_i), .wrreq(link_a.wrreq), .data(link_a.data),
    .rdreq(link_a.rdreq), .q(link_a.q), .full(link_a.full), .empty(link_a.empty),
    .almost_empty(link_a.almost_empty), .usedw(link_a.usedw),
    .b_wrreq(link_b.wrreq), .b_rdreq(link_b.rdreq), .b_full(link_b.full),
    .b_empty(link_b.empty), .b_usedw(link_b.usedw));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // tasks and expectations
  // ----------------------------------------------------------------
  function automatic logic [31:0] st(input logic pw, input logic pr, input int cnt);
    st = 32'h0;
    st[FQG_ST_PEND_WR_BIT] = pw;
    st[FQG_ST_PEND_RD_BIT] = pr;
    st[FQG_ST_FULL_BIT] = (cnt == FQG_DEPTH);
    st[FQG_ST_EMPTY_BIT] = (cnt == 0);
    st[FQG_ST_AE_BIT] = (cnt < FQG_AE_VALUE);
    st[FQG_ST_USEDW_LSB +: 4] = 4'(cnt);
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      n_errors = n_errors + 1;
    end
  endtask
  // design flops update late in the edge's time step, so on waking here
  // waitrequest and readdata still show what this edge sampled
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= d;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    // one idle edge so the next call never reassigns a strobe in this step
    @(posedge clk_i);
  endtask
  task automatic push(input logic [7:0] d);
    bus(1'b1, FQG_WDATA_OFS, {24'h0, d});
    repeat (8) @(posedge clk_i);
  endtask
  task automatic drive_b(input logic wr, input logic rdq, input int n);
    repeat (n) begin
      w = 8'($random(seed));
      link_b.wrreq <= wr;
      link_b.rdreq <= rdq;
      link_b.data <= w;
      link_c.wrreq <= wr;
      link_c.rdreq <= rdq;
      link_c.data <= w;
      @(posedge clk_i);
    end
  endtask
  task automatic close_out;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    link_b.wrreq <= 1'b0;
    link_b.rdreq <= 1'b0;
    link_b.data <= 8'h00;
    link_c.wrreq <= 1'b0;
    link_c.rdreq <= 1'b0;
    link_c.data <= 8'h00;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b0, FQG_STATUS_OFS, 32'h0);
    chk("status", rd, st(1'b0, 1'b0, 0));
    bus(1'b1, FQG_IRQ_MASK_OFS, 32'h7);
    for (int i = 0; i < 9; i++) begin
      w = 8'($random(seed));
      model.push_back(w);
      push(w);
    end
    push(8'h5a);
    bus(1'b0, FQG_STATUS_OFS, 32'h0);
    chk("status", rd, st(1'b1, 1'b0, 8));
    chk("irq", {31'h0, irq_o}, 32'h1);
    bus(1'b0, FQG_IRQ_STAT_OFS, 32'h0);
    chk("irq_stat", rd, 32'h5);
    bus(1'b1, FQG_IRQ_STAT_OFS, 32'h1);
    bus(1'b1, FQG_IRQ_MASK_OFS, 32'h3);
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    bus(1'b1, FQG_IRQ_STAT_OFS, 32'h7);
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, FQG_CTRL_OFS, 32'h1);
      repeat (6) @(posedge clk_i);
      bus(1'b0, FQG_RDATA_OFS, 32'h0);
      chk("rdata", rd, {24'h0, model.pop_front()});
    end
    bus(1'b1, FQG_CTRL_OFS, 32'h1);
    repeat (6) @(posedge clk_i);
    bus(1'b0, FQG_STATUS_OFS, 32'h0);
    chk("status", rd, st(1'b0, 1'b1, 0));
    w = 8'($random(seed));
    push(w);
    bus(1'b0, FQG_RDATA_OFS, 32'h0);
    chk("rdata", rd, {24'h0, w});
    bus(1'b0, FQG_STATUS_OFS, 32'h0);
    chk("status", rd, st(1'b0, 1'b0, 0));
    bus(1'b0, 5'h1c, 32'h0);
    chk("unmapped", rd, 32'h0);
    drive_b(1'b1, 1'b0, 10);
    @(negedge clk_i);
    chk("usedw b", {28'h0, link_b.usedw}, 32'h8);
    @(posedge clk_i);
    drive_b(1'b1, 1'b1, 4);
    last_w = w;
    @(negedge clk_i);
    chk("usedw b", {28'h0, link_b.usedw}, 32'h7);
    chk("usedw c", {28'h0, link_c.usedw}, 32'h8);
    chk("full c", {31'h0, link_c.full}, 32'h1);
    @(posedge clk_i);
    drive_b(1'b0, 1'b1, 12);
    @(negedge clk_i);
    chk("usedw b", {28'h0, link_b.usedw}, 32'h0);
    chk("q b", {24'h0, link_b.q}, {24'h0, last_w});
    chk("usedw c", {28'h0, link_c.usedw}, 32'h0);
    chk("q c", {24'h0, link_c.q}, {24'h0, last_w});
    close_out();
  end
endmodule // test_fifo_request_guard_flags
